// ### acq_consts.svh
// Offsets, codes, reset values and timing counts of the acquisition run control
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_RUN_COMMAND      20'h00000
`define OFF_RUN_STATUS       20'h0000a
`define OFF_WAIT_TIMEOUT_MS  20'h480da
`define OFF_RECORD_LENGTH    20'h02710
`define OFF_POST_EVENT_COUNT 20'h02774
`define OFF_CHANNEL_ENABLE   20'h02800
`define OFF_SETTLE_CYCLES    20'h02804
`define OFF_RUN_RESULT       20'h02808

// ----------------------------------------------------------------
// Command and status codes
// ----------------------------------------------------------------
`define CMD_LAUNCH           32'h0000000a
`define CMD_LAUNCH_IRQ_WAIT  32'h0000000b
`define CMD_HALT             32'h00000014
`define ST_WAITING_TRIGGER   32'h00000000
`define ST_TRIGGERED         32'h0000000a
`define ST_STOPPED           32'h00000014

// ----------------------------------------------------------------
// Reset values and result bits
// ----------------------------------------------------------------
`define RST_RECORD_LENGTH    32'h00000400
`define RST_POST_EVENT_COUNT 32'h00000200
`define RST_CHANNEL_ENABLE   8'h01
`define RST_SETTLE_CYCLES    32'h00000000
`define RST_WAIT_TIMEOUT_MS  32'h00000000
`define RES_DONE_BIT         0
`define RES_TIMEOUT_BIT      1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        40
`define MS_IN_NS             1000000
`define CYC_PER_MS           (`MS_IN_NS / `CLK_PERIOD_NS)

`endif

// ### acq_pkg.sv
// Types shared by the acquisition run control
package acq_pkg;

    // ----------------------------------------------------------------
    // Run phases
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ph_idle    = 6'h01,
        ph_settle  = 6'h02,
        ph_prefill = 6'h04,
        ph_armed   = 6'h08,
        ph_post    = 6'h10,
        ph_finish  = 6'h20
    } phase_t;

endpackage

// ### mem_lane_interleave.sv
// Interleaves up to four converter inputs into one memory channel ring
`timescale 1ns/1ps

module mem_lane_interleave (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clear,
    input  wire logic        rec_en,
    input  wire logic        sample_valid,
    input  wire logic [3:0]  lane_en,
    input  wire logic [63:0] lane_data,
    input  wire logic [31:0] ring_len,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [15:0]      mem_data
);

    logic [63:0] hold_q, hold_d;
    logic [3:0]  pend_q, pend_d;
    logic [31:0] ptr_q, ptr_d;
    logic        we_q, we_d;
    logic [31:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic [2:0]  n_act;
    logic [31:0] limit;

    // ----------------------------------------------------------------
    // Ring size is per-input length times active inputs
    // ----------------------------------------------------------------
    always_comb begin
        n_act = 3'h0;
        for (int i = 0; i < 4; i++) begin
            n_act = n_act + {2'h0, lane_en[i]};
        end
        limit = 32'(ring_len * {29'h0, n_act});
    end

    // ----------------------------------------------------------------
    // Lowest pending input goes out first
    // ----------------------------------------------------------------
    always_comb begin
        hold_d = hold_q;
        pend_d = pend_q;
        ptr_d  = ptr_q;
        we_d   = 1'b0;
        addr_d = addr_q;
        data_d = data_q;
        // RULE_16 lowest input first
        if (pend_q != 4'h0) begin
            for (int k = 3; k >= 0; k--) begin
                if (pend_q[k]) begin
                    data_d = hold_q[k*16 +: 16];
                end
            end
            pend_d = pend_q & (pend_q - 4'h1);
            we_d   = 1'b1;
            addr_d = ptr_q;
            // RULE_17 circular ring wrap
            ptr_d  = (ptr_q + 32'h1 >= limit) ? 32'h0 : ptr_q + 32'h1;
        end
        // Samples faster than one per active input are dropped mid-burst
        if (rec_en && sample_valid && pend_d == 4'h0) begin
            hold_d = lane_data;
            pend_d = lane_en;
        end
        if (clear) begin
            pend_d = 4'h0;
            ptr_d  = 32'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 64'h0;
            pend_q <= 4'h0;
            ptr_q  <= 32'h0;
            we_q   <= 1'b0;
            addr_q <= 32'h0;
            data_q <= 16'h0;
        end else begin
            hold_q <= hold_d;
            pend_q <= pend_d;
            ptr_q  <= ptr_d;
            we_q   <= we_d;
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    assign mem_we   = we_q;
    assign mem_addr = addr_q;
    assign mem_data = data_q;

endmodule

// ### acquisition_run_control.sv
// Run control, timeout and memory channel routing of the transient recorder
//
// Overview of operation
// RULE_01 - Launch code starts acquisition with current settings
// RULE_02 - Host programs setup; launch copies it inward (settle cycles are not copied: the settle phase reads settle_q live)
// RULE_03 - Relay boards wait settling interval before recording
// RULE_04 - Halt code ends any run immediately
// RULE_05 - Running acquisition needs no host help
// RULE_06 - Status is read-only, readable any time
// RULE_07 - Status 0 waiting, 10 triggered, 20 stopped
// RULE_08 - Completion enters stopped status by itself
// RULE_09 - Wait code starts run with completion interrupt
// RULE_10 - No trigger or clock means no completion
// RULE_11 - Host uses halt or timeout against hangs
// RULE_12 - Timeout in ms; zero waits forever
// RULE_13 - Expired timeout ends wait with error
// RULE_14 - Two memory channels, numbered 0 and 1
// RULE_15 - Inputs 0-3 to channel 0, 4-7 to 1
// RULE_16 - Shared channel interleaves round-robin, lowest first
// RULE_17 - Ring records until trigger, then post count
// RULE_18 - Pre count is length minus post count
// RULE_19 - Trigger disarmed until pre portion filled
// RULE_20 - Halt shows stopped; launch shows waiting again
// RULE_21 - Interrupt once per wait run, on stopping (a halt clears the wait and ends the run with no interrupt)
`timescale 1ns/1ps
`include "acq_consts.svh"

module acquisition_run_control #(
    parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [19:0]  reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [31:0]  reg_wdata,
    output logic [31:0]       reg_rdata,
    input  wire logic         sample_valid,
    input  wire logic [127:0] adc_data,
    input  wire logic         trigger_in,
    input  wire logic         relays_fitted,
    output logic              mem0_we,
    output logic [31:0]       mem0_addr,
    output logic [15:0]       mem0_data,
    output logic              mem1_we,
    output logic [31:0]       mem1_addr,
    output logic [15:0]       mem1_data,
    output logic              recording,
    output logic              irq
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [31:0] cmd_q, cmd_d;
    logic [31:0] len_q, len_d;
    logic [31:0] post_q, post_d;
    logic [7:0]  chan_q, chan_d;
    logic [31:0] settle_q, settle_d;
    logic [31:0] tmo_q, tmo_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wr_cmd, launch, launch_wait, halt;
    logic [31:0] status;
    logic [1:0]  result_q, result_d;

    assign wr_cmd      = reg_wr && reg_addr == `OFF_RUN_COMMAND;
    // RULE_01 launch decode
    assign launch      = wr_cmd && (reg_wdata == `CMD_LAUNCH || reg_wdata == `CMD_LAUNCH_IRQ_WAIT);
    // RULE_09 wait code decode
    assign launch_wait = wr_cmd && reg_wdata == `CMD_LAUNCH_IRQ_WAIT;
    assign halt        = wr_cmd && reg_wdata == `CMD_HALT;

    always_comb begin
        cmd_d    = cmd_q;
        len_d    = len_q;
        post_d   = post_q;
        chan_d   = chan_q;
        settle_d = settle_q;
        tmo_d    = tmo_q;
        if (reg_wr) begin
            case (reg_addr)
                `OFF_RUN_COMMAND:      cmd_d    = reg_wdata;
                `OFF_RECORD_LENGTH:    len_d    = reg_wdata;
                `OFF_POST_EVENT_COUNT: post_d   = reg_wdata;
                `OFF_CHANNEL_ENABLE:   chan_d   = reg_wdata[7:0];
                `OFF_SETTLE_CYCLES:    settle_d = reg_wdata;
                `OFF_WAIT_TIMEOUT_MS:  tmo_d    = reg_wdata;
                default:               cmd_d    = cmd_q;
            endcase
        end
        // RULE_06 status readable at any time
        rdata_d = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `OFF_RUN_COMMAND:      rdata_d = cmd_q;
                `OFF_RUN_STATUS:       rdata_d = status;
                `OFF_RECORD_LENGTH:    rdata_d = len_q;
                `OFF_POST_EVENT_COUNT: rdata_d = post_q;
                `OFF_CHANNEL_ENABLE:   rdata_d = {24'h0, chan_q};
                `OFF_SETTLE_CYCLES:    rdata_d = settle_q;
                `OFF_WAIT_TIMEOUT_MS:  rdata_d = tmo_q;
                `OFF_RUN_RESULT:       rdata_d = {30'h0, result_q};
                default:               rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_q    <= 32'h0;
            len_q    <= `RST_RECORD_LENGTH;
            post_q   <= `RST_POST_EVENT_COUNT;
            chan_q   <= `RST_CHANNEL_ENABLE;
            settle_q <= `RST_SETTLE_CYCLES;
            tmo_q    <= `RST_WAIT_TIMEOUT_MS;
            rdata_q  <= 32'h0;
        end else begin
            cmd_q    <= cmd_d;
            len_q    <= len_d;
            post_q   <= post_d;
            chan_q   <= chan_d;
            settle_q <= settle_d;
            tmo_q    <= tmo_d;
            rdata_q  <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Run sequencer
    // ----------------------------------------------------------------
    acq_pkg::phase_t state_q, state_d;
    logic [31:0] len_sh_q, len_sh_d;
    logic [31:0] pre_sh_q, pre_sh_d;
    logic [31:0] post_sh_q, post_sh_d;
    logic [7:0]  chan_sh_q, chan_sh_d;
    logic [31:0] tmo_sh_q, tmo_sh_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] pres_q, pres_d;
    logic [31:0] ms_q, ms_d;
    logic        wait_q, wait_d;
    logic        irq_q, irq_d;
    logic [31:0] pre_new;
    logic        done_evt, tmo_evt;

    // RULE_18 pre count from length and post count
    assign pre_new = (post_q >= len_q) ? 32'h0 : len_q - post_q;

    always_comb begin
        state_d   = state_q;
        len_sh_d  = len_sh_q;
        pre_sh_d  = pre_sh_q;
        post_sh_d = post_sh_q;
        chan_sh_d = chan_sh_q;
        tmo_sh_d  = tmo_sh_q;
        cnt_d     = cnt_q;
        pres_d    = pres_q;
        ms_d      = ms_q;
        wait_d    = wait_q;
        irq_d     = irq_q;
        result_d  = result_q;
        done_evt  = 1'b0;
        tmo_evt   = 1'b0;
        // RULE_05 phases advance on cycle counts, samples and trigger only
        case (state_q)
            acq_pkg::ph_idle: begin
                cnt_d = 32'h0;
            end
            // RULE_03 relay settling wait
            acq_pkg::ph_settle: begin
                if (cnt_q + 32'h1 >= settle_q) begin
                    cnt_d   = 32'h0;
                    state_d = (pre_sh_q == 32'h0) ? acq_pkg::ph_armed : acq_pkg::ph_prefill;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            // RULE_19 fill pre portion unarmed
            acq_pkg::ph_prefill: begin
                if (sample_valid) begin
                    if (cnt_q + 32'h1 >= pre_sh_q) begin
                        cnt_d   = 32'h0;
                        state_d = acq_pkg::ph_armed;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
            end
            // RULE_10 without trigger the run never completes
            acq_pkg::ph_armed: begin
                if (trigger_in) begin
                    cnt_d   = 32'h0;
                    state_d = (post_sh_q == 32'h0) ? acq_pkg::ph_finish : acq_pkg::ph_post;
                end
            end
            // RULE_17 post count then finish
            acq_pkg::ph_post: begin
                if (sample_valid) begin
                    if (cnt_q + 32'h1 >= post_sh_q) begin
                        state_d = acq_pkg::ph_finish;
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                    end
                end
            end
            // RULE_08 stop by itself on completion
            acq_pkg::ph_finish: begin
                done_evt = 1'b1;
                state_d  = acq_pkg::ph_idle;
                result_d[`RES_DONE_BIT] = 1'b1;
            end
            default: begin
                state_d = acq_pkg::ph_idle;
            end
        endcase
        // RULE_12 millisecond timeout, zero is unlimited
        if (wait_q && tmo_sh_q != 32'h0 && state_q != acq_pkg::ph_idle && state_q != acq_pkg::ph_finish) begin
            if (pres_q + 32'h1 >= CYC_PER_MS) begin
                pres_d = 32'h0;
                ms_d   = ms_q + 32'h1;
                // RULE_13 expiry ends wait with error
                if (ms_q + 32'h1 >= tmo_sh_q) begin
                    tmo_evt  = 1'b1;
                    state_d  = acq_pkg::ph_idle;
                    result_d = 2'b10;
                end
            end else begin
                pres_d = pres_q + 32'h1;
            end
        end
        // Any command write drops a pending interrupt
        if (wr_cmd) begin
            irq_d = 1'b0;
        end
        // RULE_21 one interrupt per wait run that completes or times out
        if (wait_q && (done_evt || tmo_evt)) begin
            irq_d = 1'b1;
        end
        // RULE_04 halt wins over every phase
        if (halt) begin
            state_d = acq_pkg::ph_idle;
            wait_d  = 1'b0;
        end
        if (launch) begin
            // RULE_02 copy setup on launch
            len_sh_d  = len_q;
            pre_sh_d  = pre_new;
            post_sh_d = post_q;
            chan_sh_d = chan_q;
            tmo_sh_d  = tmo_q;
            cnt_d     = 32'h0;
            pres_d    = 32'h0;
            ms_d      = 32'h0;
            wait_d    = launch_wait;
            result_d  = 2'b00;
            if (relays_fitted && settle_q != 32'h0) begin
                state_d = acq_pkg::ph_settle;
            end else if (pre_new == 32'h0) begin
                state_d = acq_pkg::ph_armed;
            end else begin
                state_d = acq_pkg::ph_prefill;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= acq_pkg::ph_idle;
            len_sh_q  <= `RST_RECORD_LENGTH;
            pre_sh_q  <= 32'h0;
            post_sh_q <= `RST_POST_EVENT_COUNT;
            chan_sh_q <= `RST_CHANNEL_ENABLE;
            tmo_sh_q  <= `RST_WAIT_TIMEOUT_MS;
            cnt_q     <= 32'h0;
            pres_q    <= 32'h0;
            ms_q      <= 32'h0;
            wait_q    <= 1'b0;
            irq_q     <= 1'b0;
            result_q  <= 2'b00;
        end else begin
            state_q   <= state_d;
            len_sh_q  <= len_sh_d;
            pre_sh_q  <= pre_sh_d;
            post_sh_q <= post_sh_d;
            chan_sh_q <= chan_sh_d;
            tmo_sh_q  <= tmo_sh_d;
            cnt_q     <= cnt_d;
            pres_q    <= pres_d;
            ms_q      <= ms_d;
            wait_q    <= wait_d;
            irq_q     <= irq_d;
            result_q  <= result_d;
        end
    end

    // RULE_07 status codes from phase
    // RULE_20 halt and launch show in status
    always_comb begin
        case (state_q)
            acq_pkg::ph_post:   status = `ST_TRIGGERED;
            acq_pkg::ph_finish: status = `ST_TRIGGERED;
            acq_pkg::ph_idle:   status = `ST_STOPPED;
            default:            status = `ST_WAITING_TRIGGER;
        endcase
    end

    assign reg_rdata = rdata_q;
    assign irq       = irq_q;
    assign recording = state_q == acq_pkg::ph_prefill || state_q == acq_pkg::ph_armed
                       || state_q == acq_pkg::ph_post;

    // ----------------------------------------------------------------
    // Memory channels
    // ----------------------------------------------------------------
    // RULE_14 two memory channels
    // RULE_15 inputs 0-3 and 4-7 split
    mem_lane_interleave u_mem0 (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .clear        (launch),
        .rec_en       (recording),
        .sample_valid (sample_valid),
        .lane_en      (chan_sh_q[3:0]),
        .lane_data    (adc_data[63:0]),
        .ring_len     (len_sh_q),
        .mem_we       (mem0_we),
        .mem_addr     (mem0_addr),
        .mem_data     (mem0_data)
    );

    mem_lane_interleave u_mem1 (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .clear        (launch),
        .rec_en       (recording),
        .sample_valid (sample_valid),
        .lane_en      (chan_sh_q[7:4]),
        .lane_data    (adc_data[127:64]),
        .ring_len     (len_sh_q),
        .mem_we       (mem1_we),
        .mem_addr     (mem1_addr),
        .mem_data     (mem1_data)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_launch_runs;
        @(posedge sys_clk) disable iff (!rstn) launch |=> state_q != acq_pkg::ph_idle;
    endproperty
    a_launch_runs: assert property (p_launch_runs) else $error("launch did not start run"); // RULE_01

    property p_setup_copied;
        @(posedge sys_clk) disable iff (!rstn) launch |=> len_sh_q == $past(len_q) && post_sh_q == $past(post_q);
    endproperty
    a_setup_copied: assert property (p_setup_copied) else $error("setup not copied on launch"); // RULE_02

    property p_settle_first;
        @(posedge sys_clk) disable iff (!rstn)
            launch && relays_fitted && settle_q > 32'h1 |=> state_q == acq_pkg::ph_settle [*2];
    endproperty
    a_settle_first: assert property (p_settle_first) else $error("settling wait skipped"); // RULE_03

    property p_halt_stops;
        @(posedge sys_clk) disable iff (!rstn) halt |=> status == `ST_STOPPED && !recording;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop run"); // RULE_04

    property p_read_status;
        @(posedge sys_clk) disable iff (!rstn)
            reg_rd && reg_addr == `OFF_RUN_STATUS |=> reg_rdata == $past(status);
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong"); // RULE_06

    property p_post_status;
        @(posedge sys_clk) disable iff (!rstn) state_q == acq_pkg::ph_post |-> status == `ST_TRIGGERED;
    endproperty
    a_post_status: assert property (p_post_status) else $error("triggered status wrong"); // RULE_07

    property p_self_stop;
        @(posedge sys_clk) disable iff (!rstn)
            state_q == acq_pkg::ph_post && sample_valid && cnt_q + 32'h1 >= post_sh_q && !wr_cmd
            ##1 !wr_cmd |=> status == `ST_STOPPED;
    endproperty
    a_self_stop: assert property (p_self_stop) else $error("run did not stop by itself"); // RULE_08

    property p_disarmed;
        @(posedge sys_clk) disable iff (!rstn)
            state_q == acq_pkg::ph_prefill && cnt_q + 32'h1 < pre_sh_q && !launch |=> state_q != acq_pkg::ph_post;
    endproperty
    a_disarmed: assert property (p_disarmed) else $error("trigger armed during prefill"); // RULE_19

    property p_irq_wait_only;
        @(posedge sys_clk) disable iff (!rstn) $rose(irq_q) |-> $past(wait_q)
            && ($past(done_evt) || $past(tmo_evt)) && ($past(launch) || status == `ST_STOPPED);
    endproperty
    a_irq_wait_only: assert property (p_irq_wait_only) else $error("interrupt outside wait run"); // RULE_21

    property p_timeout_error;
        @(posedge sys_clk) disable iff (!rstn) tmo_evt && !wr_cmd |=> result_q == 2'b10 && irq_q;
    endproperty
    a_timeout_error: assert property (p_timeout_error) else $error("timeout gave no error"); // RULE_13

    c_completion: cover property (@(posedge sys_clk) disable iff (!rstn) done_evt);
    c_timeout:    cover property (@(posedge sys_clk) disable iff (!rstn) tmo_evt);
    c_halt_post:  cover property (@(posedge sys_clk) disable iff (!rstn) halt && state_q == acq_pkg::ph_post);

endmodule

// ### adc_source_model.sv
// Converter and trigger source on the far side of the run control
`timescale 1ns/1ps

module adc_source_model (
    input  wire logic    sys_clk,
    input  wire logic    rstn,
    input  wire logic    fire,
    output logic         sample_valid,
    output logic [127:0] adc_data,
    output logic         trigger_in
);
    logic [11:0] cnt_q;

    // free-running samples
    // Spacing of 8 leaves room for a four-input burst
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q        <= 12'h000;
            sample_valid <= 1'b0;
            trigger_in   <= 1'b0;
        end else begin
            cnt_q        <= cnt_q + 12'h001;
            sample_valid <= (cnt_q[2:0] == 3'h7);
            trigger_in   <= fire;
        end
    end

    // Top nibble names the input; data moves every cycle
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            adc_data[16*k +: 16] = {k[3:0], cnt_q};
        end
    end
endmodule

// ### tb_acquisition_run_control.sv
// Self-checking bench for the acquisition run control
`timescale 1ns/1ps
`include "acq_consts.svh"

module tb_acquisition_run_control;
    logic         sys_clk, rstn, reg_wr, reg_rd, fire, sample_valid, trigger_in, relays;
    logic [19:0]  reg_addr;
    logic [31:0]  reg_wdata, reg_rdata, mem0_addr, mem1_addr, m0_src[2], m0_adr[2], m1_src, m1_adr;
    logic [127:0] adc_data;
    logic [15:0]  mem0_data, mem1_data;
    logic         mem0_we, mem1_we, recording, irq;
    int           err_count, checks, n0, n1;

    acquisition_run_control #(.CYC_PER_MS(10)) acquisition_run_control_i (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .adc_data(adc_data), .trigger_in(trigger_in), .relays_fitted(relays),
        .mem0_we(mem0_we), .mem0_addr(mem0_addr), .mem0_data(mem0_data), .mem1_we(mem1_we),
        .mem1_addr(mem1_addr), .mem1_data(mem1_data), .recording(recording), .irq(irq));
    adc_source_model adc_source_model_i (.sys_clk(sys_clk), .rstn(rstn), .fire(fire),
        .sample_valid(sample_valid), .adc_data(adc_data), .trigger_in(trigger_in));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // First memory words of the first run
    always @(posedge sys_clk) begin
        if (mem0_we && n0 < 2) begin
            m0_src[n0] = 32'(mem0_data[15:12]);
            m0_adr[n0] = mem0_addr;
            n0++;
        end
        if (mem1_we && n1 < 1) begin
            m1_src = 32'(mem1_data[15:12]);
            m1_adr = mem1_addr;
            n1++;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    // Read data is registered, so it is taken just after the following edge
    task automatic rd(input logic [19:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input string what, input logic [19:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(what, v, exp);
    endtask
    task automatic poll(input logic [31:0] exp);
        logic [31:0] v;
        for (int i = 0; i < 60; i++) begin
            rd(`OFF_RUN_STATUS, v);
            if (v === exp) break;
        end
        chk("run_status", v, exp);
    endtask
    task automatic trig;
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(20000 * 40);
        err_count++;
        end_sim();
    end

    initial begin
        {rstn, reg_wr, reg_rd, fire, reg_addr, reg_wdata} = '0;
        relays = 1'b1;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        rchk("run_status", `OFF_RUN_STATUS, `ST_STOPPED);
        rchk("record_length", `OFF_RECORD_LENGTH, `RST_RECORD_LENGTH);
        rchk("wait_timeout_ms", `OFF_WAIT_TIMEOUT_MS, `RST_WAIT_TIMEOUT_MS);
        rchk("unmapped", 20'h00100, 32'h00000000);
        wr(`OFF_RUN_STATUS, 32'h00000005);
        rchk("run_status", `OFF_RUN_STATUS, `ST_STOPPED);
        $display("reset test done");
        wr(`OFF_RECORD_LENGTH, 32'h00000008);
        wr(`OFF_POST_EVENT_COUNT, 32'h00000004);
        wr(`OFF_CHANNEL_ENABLE, 32'h00000013);
        wr(`OFF_RUN_COMMAND, `CMD_LAUNCH);
        trig();
        repeat (10) @(posedge sys_clk);
        rchk("run_status", `OFF_RUN_STATUS, `ST_WAITING_TRIGGER);
        chk("recording", 32'(recording), 32'h00000001);
        repeat (60) @(posedge sys_clk);
        trig();
        repeat (4) @(posedge sys_clk);
        rchk("run_status", `OFF_RUN_STATUS, `ST_TRIGGERED);
        poll(`ST_STOPPED);
        chk("irq", 32'(irq), 32'h00000000);
        chk("mem0 word0 input", m0_src[0], 32'h00000000);
        chk("mem0 word1 input", m0_src[1], 32'h00000001);
        chk("mem0 word0 addr", m0_adr[0], 32'h00000000);
        chk("mem0 word1 addr", m0_adr[1], m0_adr[0] + 32'h00000001);
        chk("mem1 word0 input", m1_src, 32'h00000004);
        chk("mem1 word0 addr", m1_adr, 32'h00000000);
        $display("launch test done");
        wr(`OFF_RUN_COMMAND, `CMD_LAUNCH_IRQ_WAIT);
        repeat (60) @(posedge sys_clk);
        trig();
        poll(`ST_STOPPED);
        chk("irq", 32'(irq), 32'h00000001);
        rchk("run_result", `OFF_RUN_RESULT, 32'h00000001);
        wr(`OFF_WAIT_TIMEOUT_MS, 32'h00000001);
        wr(`OFF_RUN_COMMAND, `CMD_LAUNCH_IRQ_WAIT);
        @(negedge sys_clk);
        chk("irq", 32'(irq), 32'h00000000);
        poll(`ST_STOPPED);
        rchk("run_result", `OFF_RUN_RESULT, 32'h00000002);
        chk("irq", 32'(irq), 32'h00000001);
        $display("wait test done");
        wr(`OFF_WAIT_TIMEOUT_MS, 32'h00000000);
        wr(`OFF_SETTLE_CYCLES, 32'h00000014);
        wr(`OFF_RUN_COMMAND, `CMD_LAUNCH_IRQ_WAIT);
        repeat (5) @(posedge sys_clk);
        chk("recording", 32'(recording), 32'h00000000);
        rchk("run_status", `OFF_RUN_STATUS, `ST_WAITING_TRIGGER);
        repeat (90) @(posedge sys_clk);
        chk("recording", 32'(recording), 32'h00000001);
        chk("irq", 32'(irq), 32'h00000000);
        wr(`OFF_RUN_COMMAND, `CMD_HALT);
        rchk("run_status", `OFF_RUN_STATUS, `ST_STOPPED);
        chk("irq", 32'(irq), 32'h00000000);
        relays <= 1'b0;
        wr(`OFF_RUN_COMMAND, `CMD_LAUNCH);
        @(negedge sys_clk);
        chk("recording", 32'(recording), 32'h00000001);
        $display("halt test done");
        end_sim();
    end
endmodule
